/* File: core/lcs_sequencer.sv */
// lcs_sequencer: charge cycle sequencer, top level
//
// How it works
// - charge starts only with supply above lockout, enable high, temperature in window or temperature monitor off
// - qualification is watched throughout; a lapse suspends or ends the cycle
// - status output pulls low for the whole charge cycle
// - cell below precondition level gets a trickle of ten percent
// - precondition timer expiry before the level is reached is a fault
// - cell above precondition level moves to fast charge at full current
// - fast charge runs to regulation voltage; fast timer expiry is a fault
// - at regulation voltage the loop switches to constant voltage
// - regulation voltage is a build option of four values
// - in constant voltage, current under seven percent completes the cycle
// - after completion a drop below recharge level restarts if qualified
// - supply below lockout puts the device into power-down
// - temperature judged by a window between quarter and half of the bias level
// - three safety timers of 1, 1.5 and 3 hours, scaled by the capacitor
// - precondition timer runs from qualification until fast charge starts
// - fast and elapsed timers start on entering fast charge
// - fast timer clears on entering constant voltage
// - elapsed timer expiry before termination current ends the cycle
// - enable forces termination, starts charge, clears faults, blocks recharge
// - faults flash status at 1 Hz, scaled by the capacitor; it is off when idle, done or disabled
// - enable low disables the device and ends any charge
`timescale 1ns/1ps
`default_nettype none

module lcs_sequencer #(
  parameter lcs_pkg::lcs_vreg_t REG_VOLT      = lcs_pkg::LCS_VREG_4V2,
  parameter int unsigned        TIMER_CAP_NF  = lcs_pkg::CAP_DEF_NF,
  parameter longint unsigned    PRECON_LIMIT  =
    lcs_pkg::lcs_scale(lcs_pkg::PRECON_CYCLES, lcs_pkg::CAP_DEF_NF),
  parameter longint unsigned    FAST_LIMIT    =
    lcs_pkg::lcs_scale(lcs_pkg::FAST_CYCLES, lcs_pkg::CAP_DEF_NF),
  parameter longint unsigned    ELAPSED_LIMIT =
    lcs_pkg::lcs_scale(lcs_pkg::ELAPSED_CYCLES, lcs_pkg::CAP_DEF_NF),
  parameter longint unsigned    BLINK_HALF    =
    lcs_pkg::lcs_scale(lcs_pkg::BLINK_HALF_CYCLES, lcs_pkg::CAP_DEF_NF)
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // comparator results from the analog front end
  input  wire logic       supply_above_lockout,
  input  wire logic       enable_in,
  input  wire logic       temp_above_quarter_ref,
  input  wire logic       temp_below_half_ref,
  input  wire logic       temp_monitor_off,
  input  wire logic       bat_above_precondition,
  input  wire logic       bat_at_regulation,
  input  wire logic       bat_below_recharge,
  input  wire logic       current_below_termination,
  // regulation loop controls
  output logic            gate_drive_output,
  output logic [6:0]      current_setpoint_pct,
  output logic            cv_mode,
  output logic [6:0]      term_level_pct,
  output lcs_pkg::lcs_vreg_t reg_voltage_sel,
  // open-drain status pin
  input  wire logic       charge_status_output_in,
  output logic            charge_status_output_out,
  output logic            charge_status_output_oe,
  // state visibility
  output logic            charging_active,
  output logic            timer_fault,
  output logic            temp_fault,
  output logic            charge_complete,
  output logic            power_down
);
  import lcs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int I_SUPPLY = 0;
  localparam int I_EN     = 1;
  localparam int I_TLO    = 2;
  localparam int I_THI    = 3;
  localparam int I_TOFF   = 4;
  localparam int I_PTH    = 5;
  localparam int I_REG    = 6;
  localparam int I_RTH    = 7;
  localparam int I_TERM   = 8;

  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] s1_reg, s2_reg, s3_reg;
  logic [N_IN-1:0] filt_reg, filt_next;

  assign raw_in = {current_below_termination,
                   bat_below_recharge,
                   bat_at_regulation,
                   bat_above_precondition,
                   temp_monitor_off,
                   temp_below_half_ref,
                   temp_above_quarter_ref,
                   enable_in,
                   supply_above_lockout};

  // a level counts only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < N_IN; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg   <= IN_RST;
      s2_reg   <= IN_RST;
      s3_reg   <= IN_RST;
      filt_reg <= IN_RST;
    end else begin
      s1_reg   <= raw_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  logic supply_ok;
  logic en_ok;
  logic temp_ok;
  logic qualified;

  assign supply_ok = filt_reg[I_SUPPLY];
  assign en_ok     = filt_reg[I_EN];
  // window between a quarter and a half of the bias reference
  assign temp_ok   = (filt_reg[I_TLO] && filt_reg[I_THI])
                     || filt_reg[I_TOFF];
  assign qualified = supply_ok && en_ok && temp_ok;

  // ----------------------------------------------------------------
  // safety timers
  // ----------------------------------------------------------------
  lcs_tmr_if tif ();

  lcs_timers #(
    .PRECON_LIMIT  (lcs_scale(PRECON_LIMIT, TIMER_CAP_NF)),
    .FAST_LIMIT    (lcs_scale(FAST_LIMIT, TIMER_CAP_NF)),
    .ELAPSED_LIMIT (lcs_scale(ELAPSED_LIMIT, TIMER_CAP_NF)),
    .BLINK_HALF    (lcs_scale(BLINK_HALF, TIMER_CAP_NF))
  ) u_timers (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tif      (tif)
  );

  // ----------------------------------------------------------------
  // charge state machine
  // ----------------------------------------------------------------
  lcs_state_t state_reg, state_next;

  // timers run off the registered state, so a move clears them one cycle later
  assign tif.run_precon  = (state_reg == ST_PRECON);
  assign tif.run_fast    = (state_reg == ST_FAST);
  assign tif.run_elapsed = (state_reg == ST_FAST)
                           || (state_reg == ST_CV);

  always_comb begin
    state_next = state_reg;
    if (!supply_ok) begin
      state_next = ST_OFF;
    end else if (!en_ok) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_next = ST_QUAL;
        end
        ST_QUAL: begin
          if (!temp_ok) begin
            state_next = ST_TEMP_FAULT;
          end else if (qualified) begin
            state_next = filt_reg[I_PTH] ? ST_FAST : ST_PRECON;
          end
        end
        ST_PRECON: begin
          if (!temp_ok) begin
            state_next = ST_TEMP_FAULT;
          end else if (filt_reg[I_PTH]) begin
            state_next = ST_FAST;
          end else if (tif.precon_expired) begin
            state_next = ST_TIMER_FAULT;
          end
        end
        ST_FAST: begin
          if (!temp_ok) begin
            state_next = ST_TEMP_FAULT;
          end else if (filt_reg[I_REG]) begin
            state_next = ST_CV;
          end else if (tif.fast_expired) begin
            state_next = ST_TIMER_FAULT;
          end
        end
        ST_CV: begin
          if (!temp_ok) begin
            state_next = ST_TEMP_FAULT;
          end else if (filt_reg[I_TERM]) begin
            state_next = ST_DONE;
          end else if (tif.elapsed_expired) begin
            state_next = ST_DONE;
          end
        end
        ST_DONE: begin
          if (filt_reg[I_RTH] && qualified) begin
            state_next = ST_QUAL;
          end
        end
        ST_TIMER_FAULT: begin
          // held until enable drops or the supply fails
          state_next = ST_TIMER_FAULT;
        end
        ST_TEMP_FAULT: begin
          // charge is only suspended; it requalifies from the start
          if (temp_ok) begin
            state_next = ST_QUAL;
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs, decoded from the next state
  // ----------------------------------------------------------------
  logic               drive_reg, drive_next;
  logic [6:0]         pct_reg, pct_next;
  logic               cv_reg, cv_next;
  logic               stat_oe_reg, stat_oe_next;
  logic               active_reg, active_next;
  logic               tfault_reg, tfault_next;
  logic               hfault_reg, hfault_next;
  logic               done_reg, done_next;
  logic               pdown_reg, pdown_next;
  logic [6:0]         term_reg;
  lcs_vreg_t          vsel_reg;

  always_comb begin
    active_next  = (state_next == ST_PRECON) || (state_next == ST_FAST)
                   || (state_next == ST_CV);
    drive_next   = active_next;
    cv_next      = (state_next == ST_CV);
    tfault_next  = (state_next == ST_TIMER_FAULT);
    hfault_next  = (state_next == ST_TEMP_FAULT);
    done_next    = (state_next == ST_DONE);
    pdown_next   = !supply_ok;
    case (state_next)
      ST_PRECON: pct_next = PCT_PRECON;
      ST_FAST:   pct_next = PCT_FAST;
      ST_CV:     pct_next = PCT_FAST;
      default:   pct_next = PCT_OFF;
    endcase
    // pin pulled low while charging, flashing on faults, else released
    if (active_next) begin
      stat_oe_next = 1'b1;
    end else if (tfault_next || hfault_next) begin
      stat_oe_next = tif.blink;
    end else begin
      stat_oe_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_reg   <= 1'b0;
      pct_reg     <= PCT_OFF;
      cv_reg      <= 1'b0;
      stat_oe_reg <= 1'b0;
      active_reg  <= 1'b0;
      tfault_reg  <= 1'b0;
      hfault_reg  <= 1'b0;
      done_reg    <= 1'b0;
      pdown_reg   <= 1'b1;
      term_reg    <= PCT_OFF;
      vsel_reg    <= LCS_VREG_4V1;
    end else begin
      drive_reg   <= drive_next;
      pct_reg     <= pct_next;
      cv_reg      <= cv_next;
      stat_oe_reg <= stat_oe_next;
      active_reg  <= active_next;
      tfault_reg  <= tfault_next;
      hfault_reg  <= hfault_next;
      done_reg    <= done_next;
      pdown_reg   <= pdown_next;
      term_reg    <= PCT_TERM;
      vsel_reg    <= REG_VOLT;
    end
  end

  assign gate_drive_output        = drive_reg;
  assign current_setpoint_pct     = pct_reg;
  assign cv_mode                  = cv_reg;
  assign term_level_pct           = term_reg;
  assign reg_voltage_sel          = vsel_reg;
  // open drain: only ever drives low
  assign charge_status_output_out = 1'b0;
  assign charge_status_output_oe  = stat_oe_reg;
  assign charging_active          = active_reg;
  assign timer_fault              = tfault_reg;
  assign temp_fault               = hfault_reg;
  assign charge_complete          = done_reg;
  assign power_down               = pdown_reg;

endmodule

`default_nettype wire

/* File: core/lcs_timers.sv */
// lcs_timers: the three safety timers and the status flash generator
`timescale 1ns/1ps
`default_nettype none

module lcs_timers
  import lcs_pkg::*;
#(
  parameter longint unsigned PRECON_LIMIT  = PRECON_CYCLES,
  parameter longint unsigned FAST_LIMIT    = FAST_CYCLES,
  parameter longint unsigned ELAPSED_LIMIT = ELAPSED_CYCLES,
  parameter longint unsigned BLINK_HALF    = BLINK_HALF_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  lcs_tmr_if.tmr    tif
);

  localparam logic [TMR_W-1:0] PRE_END = TMR_W'(PRECON_LIMIT - 64'd1);
  localparam logic [TMR_W-1:0] FST_END = TMR_W'(FAST_LIMIT - 64'd1);
  localparam logic [TMR_W-1:0] ELP_END = TMR_W'(ELAPSED_LIMIT - 64'd1);
  localparam logic [TMR_W-1:0] BLK_END = TMR_W'(BLINK_HALF - 64'd1);

  logic [TMR_W-1:0] pre_cnt_reg, pre_cnt_next;
  logic [TMR_W-1:0] fst_cnt_reg, fst_cnt_next;
  logic [TMR_W-1:0] elp_cnt_reg, elp_cnt_next;
  logic [TMR_W-1:0] blk_cnt_reg, blk_cnt_next;
  logic             pre_exp_reg, pre_exp_next;
  logic             fst_exp_reg, fst_exp_next;
  logic             elp_exp_reg, elp_exp_next;
  logic             blink_reg,   blink_next;

  // a stopped timer is held at zero, so each start counts the full period
  function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] cnt,
                                                input logic run,
                                                input logic [TMR_W-1:0] last);
    tmr_step = !run ? '0 : (cnt == last) ? cnt : cnt + TMR_W'(1);
  endfunction

  always_comb begin
    pre_cnt_next = tmr_step(pre_cnt_reg, tif.run_precon, PRE_END);
    fst_cnt_next = tmr_step(fst_cnt_reg, tif.run_fast, FST_END);
    elp_cnt_next = tmr_step(elp_cnt_reg, tif.run_elapsed, ELP_END);
    pre_exp_next = tif.run_precon && (pre_cnt_reg == PRE_END);
    fst_exp_next = tif.run_fast && (fst_cnt_reg == FST_END);
    elp_exp_next = tif.run_elapsed && (elp_cnt_reg == ELP_END);
    blk_cnt_next = (blk_cnt_reg == BLK_END) ? '0 : blk_cnt_reg + TMR_W'(1);
    blink_next   = (blk_cnt_reg == BLK_END) ? !blink_reg : blink_reg;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_reg <= '0;
      fst_cnt_reg <= '0;
      elp_cnt_reg <= '0;
      blk_cnt_reg <= '0;
      pre_exp_reg <= 1'b0;
      fst_exp_reg <= 1'b0;
      elp_exp_reg <= 1'b0;
      blink_reg   <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      fst_cnt_reg <= fst_cnt_next;
      elp_cnt_reg <= elp_cnt_next;
      blk_cnt_reg <= blk_cnt_next;
      pre_exp_reg <= pre_exp_next;
      fst_exp_reg <= fst_exp_next;
      elp_exp_reg <= elp_exp_next;
      blink_reg   <= blink_next;
    end
  end

  assign tif.precon_expired  = pre_exp_reg;
  assign tif.fast_expired    = fst_exp_reg;
  assign tif.elapsed_expired = elp_exp_reg;
  assign tif.blink           = blink_reg;

endmodule

`default_nettype wire

/* File: shared/lcs_pkg.sv */
// lcs_pkg: constants, types and helpers for the lithium cell charge sequencer
package lcs_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd250_000_000;

  // ----------------------------------------------------------------
  // safety timer periods, in tenths of an hour at the reference capacitor
  // ----------------------------------------------------------------
  localparam longint unsigned TENTH_HOUR_S     = 64'd360;
  localparam longint unsigned PRECON_TENTH_HR  = 64'd10;
  localparam longint unsigned FAST_TENTH_HR    = 64'd15;
  localparam longint unsigned ELAPSED_TENTH_HR = 64'd30;
  localparam longint unsigned PRECON_CYCLES    = PRECON_TENTH_HR * TENTH_HOUR_S * CLK_HZ;
  localparam longint unsigned FAST_CYCLES      = FAST_TENTH_HR * TENTH_HOUR_S * CLK_HZ;
  localparam longint unsigned ELAPSED_CYCLES   = ELAPSED_TENTH_HR * TENTH_HOUR_S * CLK_HZ;

  // status flash: 1 Hz, equal on and off time
  localparam longint unsigned BLINK_HZ          = 64'd1;
  localparam longint unsigned BLINK_HALF_CYCLES = CLK_HZ / (64'd2 * BLINK_HZ);

  // timing capacitor scaling, in nF
  localparam int unsigned CAP_REF_NF = 100;
  localparam int unsigned CAP_DEF_NF = 100;

  localparam int TMR_W = 44;

  // ----------------------------------------------------------------
  // current requests, percent of the fast charge current
  // ----------------------------------------------------------------
  localparam logic [6:0] PCT_OFF    = 7'h00;
  localparam logic [6:0] PCT_PRECON = 7'h0a;
  localparam logic [6:0] PCT_FAST   = 7'h64;
  localparam logic [6:0] PCT_TERM   = 7'h07;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  localparam int N_IN = 9;
  localparam logic [N_IN-1:0] IN_RST = 9'h000;

  typedef enum logic [1:0] {
    LCS_VREG_4V1,
    LCS_VREG_4V2,
    LCS_VREG_8V2,
    LCS_VREG_8V4
  } lcs_vreg_t;

  typedef enum {
    ST_OFF,
    ST_QUAL,
    ST_PRECON,
    ST_FAST,
    ST_CV,
    ST_DONE,
    ST_TIMER_FAULT,
    ST_TEMP_FAULT
  } lcs_state_t;

  // timer period scaled linearly by the timing capacitor
  function automatic longint unsigned lcs_scale(input longint unsigned base,
                                                input int unsigned cap_nf);
    longint unsigned r;
    r = (base * longint'(cap_nf)) / longint'(CAP_REF_NF);
    lcs_scale = (r == 64'd0) ? 64'd1 : r;
  endfunction

endpackage

/* File: shared/lcs_tmr_if.sv */
// lcs_tmr_if: run controls and expiry flags between sequencer and its timers
`timescale 1ns/1ps
`default_nettype none

interface lcs_tmr_if;
  logic run_precon;
  logic run_fast;
  logic run_elapsed;
  logic precon_expired;
  logic fast_expired;
  logic elapsed_expired;
  logic blink;

  modport ctl (
    output run_precon,
    output run_fast,
    output run_elapsed,
    input  precon_expired,
    input  fast_expired,
    input  elapsed_expired,
    input  blink
  );

  modport tmr (
    input  run_precon,
    input  run_fast,
    input  run_elapsed,
    output precon_expired,
    output fast_expired,
    output elapsed_expired,
    output blink
  );
endinterface

`default_nettype wire

/* File: tb/lcs_cell_model.sv */
// partner: behavioural cell that charges while the pass transistor conducts
`timescale 1ns/1ps
`default_nettype none

module lcs_cell_model (
  input  wire logic       core_clk,
  input  wire logic       gate_drive_output,
  input  wire logic [6:0] current_setpoint_pct,
  input  wire logic       cv_mode,
  input  wire logic       stall,
  input  wire logic       drain,
  input  wire logic       empty,
  output logic            bat_above_precondition,
  output logic            bat_at_regulation,
  output logic            bat_below_recharge,
  output logic            current_below_termination
);
  int lvl = 0;
  int cur = 40;
  int dv  = 0;

  // a stalled cell stops rising and its taper current stays put
  always @(posedge core_clk) begin
    dv <= (dv + 1) % 4;
    if (empty) begin
      lvl <= 0;
    end else if (drain) begin
      lvl <= 60;
    end else if (gate_drive_output && !stall && !cv_mode && dv == 0) begin
      lvl <= (lvl + ((current_setpoint_pct == 7'h0a) ? 1 : 2) > 80) ? 80 :
             lvl + ((current_setpoint_pct == 7'h0a) ? 1 : 2);
    end
    if (!cv_mode) begin
      cur <= 40;
    end else if (!stall && dv == 0 && cur > 0) begin
      cur <= cur - 1;
    end
  end
  assign bat_above_precondition    = lvl > 30;
  assign bat_at_regulation         = lvl >= 80;
  assign bat_below_recharge        = lvl < 70;
  assign current_below_termination = !gate_drive_output || cur == 0;
endmodule

`default_nettype wire

/* File: tb/lcs_sequencer_chk.sv */
// checker: concurrent assertions on the charge sequencer ports
`timescale 1ns/1ps
`default_nettype none

module lcs_sequencer_chk #(
  parameter longint unsigned PRECON_LIMIT = 200
) (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       supply_above_lockout,
  input wire logic       enable_in,
  input wire logic       gate_drive_output,
  input wire logic [6:0] current_setpoint_pct,
  input wire logic       cv_mode,
  input wire logic [6:0] term_level_pct,
  input wire logic       charge_status_output_oe,
  input wire logic       charging_active,
  input wire logic       timer_fault,
  input wire logic       temp_fault,
  input wire logic       charge_complete,
  input wire logic       power_down
);
  logic        in_pre;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // cycles spent in preconditioning, bounds the trickle phase
  assign in_pre = charging_active && (current_setpoint_pct == 7'h0a);
  always_comb begin
    cnt_next = in_pre ? cnt_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  a_status_on: assert property (charging_active |-> charge_status_output_oe)
    else $error("status released while charging");
  a_status_off: assert property ((charge_complete || power_down) |-> !charge_status_output_oe)
    else $error("status pulled while idle");
  a_fault_blink: assert property ((timer_fault && $rose(charge_status_output_oe)) |=> charge_status_output_oe[*8])
    else $error("fault flash too short");
  a_fault_nodrive: assert property ((timer_fault || temp_fault) |-> !gate_drive_output && !charging_active)
    else $error("drive on in fault");
  a_cv_full: assert property (cv_mode |-> gate_drive_output && current_setpoint_pct == 7'h64)
    else $error("constant voltage without full drive");
  a_term_level: assert property ($past(nrst) |-> term_level_pct == 7'h07)
    else $error("termination level wrong");
  a_enable_stop: assert property (!enable_in[*6] |=> !gate_drive_output && !charging_active)
    else $error("charge kept with enable low");
  a_supply_pd: assert property (!supply_above_lockout[*6] |=> power_down && !gate_drive_output)
    else $error("no power down on low supply");
  a_done_cv: assert property ($rose(charge_complete) |-> $past(cv_mode))
    else $error("completion outside constant voltage");
  a_precon_bound: assert property (cnt_reg <= PRECON_LIMIT + 2)
    else $error("precondition outlived its timer");
  a_precon_fault: assert property ((timer_fault && $past(in_pre)) |-> cnt_reg >= PRECON_LIMIT)
    else $error("precondition timer expired early");
endmodule

// the bound limit is the one the timers really count, after capacitor scaling
bind lcs_sequencer lcs_sequencer_chk #(
  .PRECON_LIMIT (lcs_pkg::lcs_scale(PRECON_LIMIT, TIMER_CAP_NF))
) chk_u (
  .core_clk                (core_clk),
  .nrst                    (nrst),
  .supply_above_lockout    (supply_above_lockout),
  .enable_in               (enable_in),
  .gate_drive_output       (gate_drive_output),
  .current_setpoint_pct    (current_setpoint_pct),
  .cv_mode                 (cv_mode),
  .term_level_pct          (term_level_pct),
  .charge_status_output_oe (charge_status_output_oe),
  .charging_active         (charging_active),
  .timer_fault             (timer_fault),
  .temp_fault              (temp_fault),
  .charge_complete         (charge_complete),
  .power_down              (power_down)
);

`default_nettype wire

/* File: tb/lcs_sequencer_tb.sv */
// testbench: charge, recharge, fault and shutdown paths of the sequencer
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module lcs_sequencer_tb;
  import lcs_pkg::*;
  // snapshot: pd, timer fault, temp fault, done, active, cv, setpoint
  localparam logic [12:0] S_OFF = 13'h0000, S_PD = 13'h1000, S_PRE = 13'h010a;
  localparam logic [12:0] S_FAST = 13'h0164, S_CV = 13'h01e4, S_DONE = 13'h0200;
  localparam logic [12:0] S_TF = 13'h0800, S_TMP = 13'h0400;
  logic core_clk = 1'b0, nrst = 1'b0, sup = 1'b1, en = 1'b1, tq = 1'b1, th = 1'b1;
  logic toff = 1'b0, stall = 1'b0, drain = 1'b0, empty = 1'b0;
  logic bpre, breg, brch, iterm, gate, cv, oe, sout, act, tf, tmp, done, pd;
  logic [6:0] pct, term;
  lcs_vreg_t vsel;
  logic [12:0] exp_q[$];
  logic [12:0] prev = 13'h1000;
  logic [12:0] snap;
  logic [12:0] want;
  int miscompares = 0, cmp_count = 0;
  int unsigned seed = 53;

  always #2 core_clk = ~core_clk;

  lcs_sequencer #(.PRECON_LIMIT(200), .FAST_LIMIT(300), .ELAPSED_LIMIT(600),
    .BLINK_HALF(20)) dut_u (.core_clk(core_clk), .nrst(nrst),
    .supply_above_lockout(sup), .enable_in(en), .temp_above_quarter_ref(tq),
    .temp_below_half_ref(th), .temp_monitor_off(toff), .bat_above_precondition(bpre),
    .bat_at_regulation(breg), .bat_below_recharge(brch),
    .current_below_termination(iterm), .gate_drive_output(gate),
    .current_setpoint_pct(pct), .cv_mode(cv), .term_level_pct(term),
    .reg_voltage_sel(vsel), .charge_status_output_in(!oe),
    .charge_status_output_out(sout), .charge_status_output_oe(oe),
    .charging_active(act), .timer_fault(tf), .temp_fault(tmp),
    .charge_complete(done), .power_down(pd));

  lcs_cell_model cell_u (.core_clk(core_clk), .gate_drive_output(gate),
    .current_setpoint_pct(pct), .cv_mode(cv), .stall(stall), .drain(drain),
    .empty(empty), .bat_above_precondition(bpre), .bat_at_regulation(breg),
    .bat_below_recharge(brch), .current_below_termination(iterm));

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic note(input logic [12:0] s);
    exp_q.push_back(s);
  endtask

  // bounded wait for every noted phase to show up at the outputs
  task automatic settle(input int lim);
    int i;
    i = 0;
    while (exp_q.size() != 0 && i < lim) begin
      @(posedge core_clk);
      i++;
    end
    `CHK(exp_q.size(), 0)
    exp_q.delete();
    #1;
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(negedge core_clk) begin
    if (nrst) begin
      snap = {pd, tf, tmp, done, act, cv, pct};
      if (snap !== prev) begin
        if (exp_q.size() == 0) `CHK(snap, prev)
        else begin
          // pop once: the compare macro reads its expected value twice
          want = exp_q.pop_front();
          `CHK(snap, want)
        end
        prev = snap;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    tick(16);
    nrst = 1'b1;
    note(S_OFF);
    note(S_PRE);
    note(S_FAST);
    note(S_CV);
    note(S_DONE);
    settle(2000);
    `CHK(vsel, LCS_VREG_4V2)
    `CHK(term, PCT_TERM)
    `CHK(sout, 1'b0)
    drain = 1'b1;
    tick(1);
    drain = 1'b0;
    note(S_OFF);
    note(S_FAST);
    note(S_CV);
    note(S_DONE);
    settle(1000);
    drain = 1'b1;
    tick(1);
    drain = 1'b0;
    note(S_OFF);
    note(S_FAST);
    settle(100);
    stall = 1'b1;
    tick(xs() % 16 + 1);
    if (xs() % 2 == 0) tq = 1'b0;
    else th = 1'b0;
    note(S_TMP);
    settle(100);
    tick(xs() % 16 + 1);
    tq = 1'b1;
    th = 1'b1;
    note(S_OFF);
    note(S_FAST);
    note(S_TF);
    settle(500);
    // leave the fault only while the flash is off, so no lit phase is cut short
    @(negedge oe);
    tick(1);
    en = 1'b0;
    note(S_OFF);
    settle(100);
    stall = 1'b0;
    en = 1'b1;
    note(S_FAST);
    note(S_CV);
    settle(200);
    stall = 1'b1;
    toff = 1'b1;
    tq = 1'b0;
    note(S_DONE);
    settle(1000);
    tq = 1'b1;
    tick(8);
    toff = 1'b0;
    en = 1'b0;
    note(S_OFF);
    settle(100);
    stall = 1'b0;
    empty = 1'b1;
    tick(1);
    empty = 1'b0;
    stall = 1'b1;
    en = 1'b1;
    note(S_PRE);
    note(S_TF);
    settle(400);
    @(negedge oe);
    tick(1);
    sup = 1'b0;
    note(S_PD);
    settle(100);
    sup = 1'b1;
    stall = 1'b0;
    note(S_OFF);
    note(S_PRE);
    note(S_FAST);
    settle(400);
    en = 1'b0;
    note(S_OFF);
    settle(100);
    wrap_up();
  end
endmodule

`default_nettype wire
